// File: common/fdl_pkg.sv
// Shared constants, types and operand classification for the floating point execution block
package fdl_pkg;

    // ******************************************************************
    // Opcode decode fields
    // ******************************************************************
    localparam logic [3:0] OP_GROUP  = 4'hf;
    localparam logic [3:0] LO_DIV    = 4'h3;
    localparam logic [3:0] LO_MAC    = 4'he;
    localparam logic [3:0] LO_MISC   = 4'hd;
    localparam logic [3:0] MID_ZERO  = 4'h8;
    localparam logic [3:0] MID_ONE   = 4'h9;
    localparam logic [3:0] MID_XFER  = 4'h1;
    localparam logic [3:0] MID_FLOAT = 4'h2;

    // ******************************************************************
    // Data words and timing
    // ******************************************************************
    localparam logic [31:0] FP_ZERO     = 32'h00000000;
    localparam logic [31:0] FP_ONE      = 32'h3f800000;
    localparam logic [31:0] FP_QNAN     = 32'h7fc00000;
    localparam logic        READY_RESET = 1'b1;
    localparam int          DIV_ISSUE_CYC = 13;
    localparam int          DIV_LATENCY   = 14;
    localparam int          PIPE_LATENCY  = 2;
    // Two quotient bits per cycle; counter starts one below the issue count
    localparam logic [3:0]  DIV_STEPS  = 4'(DIV_ISSUE_CYC - 1);
    localparam logic [9:0]  EXP_BIAS   = 10'h07f;
    localparam logic [9:0]  EXP_MAX    = 10'h0ff;
    localparam logic [9:0]  EXP_I2F    = 10'h09e;

    // ******************************************************************
    // Types
    // ******************************************************************
    typedef enum logic [1:0] {ARITH_MUL = 2'b00, ARITH_ADD = 2'b01, ARITH_I2F = 2'b10} fdl_arith_e;
    typedef enum logic [1:0] {DIV_IDLE = 2'b00, DIV_RUN = 2'b01, DIV_WB = 2'b10} fdl_div_e;
    typedef struct packed {logic invalid; logic divZero;} fdl_cause_s;
    typedef struct packed {logic zero; logic inf; logic nan; logic snan;} fdl_class_s;
    typedef struct packed {
        logic        valid;
        logic        toXfer;
        logic        isMac;
        logic [3:0]  dst;
        logic [31:0] data;
        fdl_cause_s  cause;
    } fdl_stage_s;

    // Denormals classify as zero, so the multiply, add and divide paths flush them; the transfer copy passes them unchanged
    function automatic fdl_class_s fdlClassify(input logic [31:0] w);
        fdl_class_s c;
        c.zero = (w[30:23] == 8'h00);
        c.inf  = (w[30:23] == 8'hff) && (w[22:0] == 23'h0);
        c.nan  = (w[30:23] == 8'hff) && (w[22:0] != 23'h0);
        c.snan = c.nan && !w[22];
        return c;
    endfunction

endpackage

// File: design/fdl_fp_arith.sv
// Combinational single precision multiply, add and integer conversion
`timescale 1ns/1ps
`default_nettype none
module fdl_fp_arith
    import fdl_pkg::*;
(
    // Operands and selection
    input  wire logic [31:0] opA,
    input  wire logic [31:0] opB,
    input  wire fdl_arith_e  sel,
    // Result
    output logic [31:0]      result,
    output fdl_cause_s       cause
);

    fdl_class_s ca;
    fdl_class_s cb;
    assign ca = fdlClassify(opA);
    assign cb = fdlClassify(opB);

    // ******************************************************************
    // Arithmetic with truncation; tiny results flush to zero
    // ******************************************************************
    always_comb
    begin
        logic        s;
        logic        fin;
        logic [9:0]  e;
        logic [22:0] frac;
        logic [47:0] prod;
        logic [25:0] mb;
        logic [25:0] ms;
        logic [25:0] sum;
        logic [31:0] big;
        logic [31:0] sml;
        logic [31:0] mag;
        s = 1'b0;
        fin = 1'b0;
        e = 10'h0;
        frac = 23'h0;
        prod = 48'h0;
        mb = 26'h0;
        ms = 26'h0;
        sum = 26'h0;
        big = 32'h0;
        sml = 32'h0;
        mag = 32'h0;
        result = FP_ZERO;
        cause = '0;
        unique case (sel)
            ARITH_MUL:
            begin
                s = opA[31] ^ opB[31];
                if (ca.nan || cb.nan)
                begin
                    result = FP_QNAN;
                    cause.invalid = ca.snan || cb.snan;
                end
                else if ((ca.inf && cb.zero) || (ca.zero && cb.inf))
                begin
                    result = FP_QNAN;
                    cause.invalid = 1'b1;
                end
                else if (ca.inf || cb.inf)
                    result = {s, 8'hff, 23'h0};
                else if (ca.zero || cb.zero)
                    result = {s, 31'h0};
                else
                begin
                    prod = {1'b1, opA[22:0]} * {1'b1, opB[22:0]};
                    e = {2'b0, opA[30:23]} + {2'b0, opB[30:23]} - EXP_BIAS + {9'h0, prod[47]};
                    frac = prod[47] ? prod[46:24] : prod[45:23];
                    fin = 1'b1;
                end
            end
            ARITH_ADD:
            begin
                if (ca.nan || cb.nan)
                begin
                    result = FP_QNAN;
                    cause.invalid = ca.snan || cb.snan;
                end
                else if (ca.inf && cb.inf && (opA[31] != opB[31]))
                begin
                    result = FP_QNAN;
                    cause.invalid = 1'b1;
                end
                else if (ca.inf)
                    result = {opA[31], 8'hff, 23'h0};
                else if (cb.inf)
                    result = {opB[31], 8'hff, 23'h0};
                else if (ca.zero && cb.zero)
                    result = {opA[31] & opB[31], 31'h0};
                else if (ca.zero)
                    result = opB;
                else if (cb.zero)
                    result = opA;
                else
                begin
                    // Align the smaller magnitude under the larger one
                    big = (opA[30:0] >= opB[30:0]) ? opA : opB;
                    sml = (opA[30:0] >= opB[30:0]) ? opB : opA;
                    mb = {2'b01, big[22:0], 1'b0};
                    ms = {2'b01, sml[22:0], 1'b0} >> (big[30:23] - sml[30:23]);
                    sum = (big[31] == sml[31]) ? mb + ms : mb - ms;
                    s = big[31];
                    e = {2'b0, big[30:23]};
                    if (sum[25])
                    begin
                        sum = sum >> 1;
                        e = e + 10'h1;
                    end
                    for (int i = 0; i < 25; i++)
                    begin
                        if (!sum[24] && sum != 26'h0)
                        begin
                            sum = sum << 1;
                            e = e - 10'h1;
                        end
                    end
                    frac = sum[23:1];
                    fin = (sum != 26'h0);
                end
            end
            ARITH_I2F:
            begin
                s = opA[31];
                mag = s ? 32'(-opA) : opA;
                e = EXP_I2F;
                for (int i = 0; i < 31; i++)
                begin
                    if (!mag[31])
                    begin
                        mag = mag << 1;
                        e = e - 10'h1;
                    end
                end
                frac = mag[30:8];
                fin = (opA != 32'h0);
            end
            default:
                result = FP_ZERO;
        endcase
        // Pack finite results, saturating to infinity or flushing to zero
        if (fin)
        begin
            if ($signed(e) >= $signed(EXP_MAX))
                result = {s, 8'hff, 23'h0};
            else if ($signed(e) <= 0)
                result = {s, 31'h0};
            else
                result = {s, e[7:0], frac};
        end
    end

endmodule // fdl_fp_arith
`default_nettype wire

// File: design/fdl_fpu_exec.sv
// Floating point execution block: divide, constant loads, transfer copy, convert and multiply-accumulate
`timescale 1ns/1ps
`default_nettype none
module fdl_fpu_exec
    import fdl_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Instruction issue
    input  wire logic        issueValid,
    input  wire logic [15:0] issueOpcode,
    output logic             issueReady_q,
    // Results and state
    output logic             resultValid_q,
    output fdl_cause_s       statusCause_q,
    output logic [31:0]      transferReg_q,
    // Register read port
    input  wire logic [3:0]  rdIdx,
    output logic [31:0]      rdData_q
);

    typedef struct packed {
        logic [15:0][31:0] fr;
        logic [31:0]       xfer;
        fdl_cause_s        cause;
        logic              ready;
        logic              resValid;
        logic [31:0]       rdData;
        fdl_stage_s        stage;
        fdl_div_e          divSt;
        logic [3:0]        divCnt;
        logic [3:0]        divDst;
        logic [24:0]       divRem;
        logic [23:0]       divDen;
        logic [25:0]       divQ;
        logic              divSign;
        logic [9:0]        divExp;
        logic              divSpecial;
        logic [31:0]       divSpecData;
        fdl_cause_s        divCause;
    } fdl_state_s;

    fdl_state_s st_q;
    fdl_state_s st_d;

    // ******************************************************************
    // Decode
    // ******************************************************************
    logic        taken;
    logic [3:0]  dstIdx;
    logic [3:0]  srcIdx;
    logic        isDiv;
    logic        isMac;
    logic        isMisc;
    logic [31:0] dstVal;
    logic [31:0] srcVal;
    fdl_class_s  cNum;
    fdl_class_s  cDen;
    logic [31:0] frontRes;
    fdl_cause_s  frontCause;
    logic [31:0] backRes;
    fdl_cause_s  backCause;

    assign taken  = issueValid && st_q.ready && (issueOpcode[15:12] == OP_GROUP);
    assign dstIdx = issueOpcode[11:8];
    assign srcIdx = issueOpcode[7:4];
    assign isDiv  = issueOpcode[3:0] == LO_DIV;
    assign isMac  = issueOpcode[3:0] == LO_MAC;
    assign isMisc = issueOpcode[3:0] == LO_MISC;
    assign dstVal = st_q.fr[dstIdx];
    assign srcVal = st_q.fr[srcIdx];
    assign cNum   = fdlClassify(dstVal);
    assign cDen   = fdlClassify(srcVal);

    // Issue-side unit: multiply step or integer conversion
    fdl_fp_arith u_front (
        .opA    (isMac ? st_q.fr[0] : st_q.xfer),
        .opB    (srcVal),
        .sel    (isMac ? ARITH_MUL : ARITH_I2F),
        .result (frontRes),
        .cause  (frontCause)
    );

    // Second-stage unit: accumulate step of multiply-accumulate
    fdl_fp_arith u_back (
        .opA    (st_q.stage.data),
        .opB    (st_q.fr[st_q.stage.dst]),
        .sel    (ARITH_ADD),
        .result (backRes),
        .cause  (backCause)
    );

    // ******************************************************************
    // Next state
    // ******************************************************************
    always_comb
    begin
        logic [9:0]  e;
        logic [22:0] frac;
        logic        divWb;
        fdl_cause_s  wbDivCause;
        e = 10'h0;
        frac = 23'h0;
        st_d = st_q;
        st_d.resValid = 1'b0;
        st_d.stage.valid = 1'b0;
        st_d.rdData = st_q.fr[rdIdx];
        divWb = (st_q.divSt == DIV_WB);
        wbDivCause = divWb ? st_q.divCause : '0;

        // Divider runs two restoring quotient bits per cycle
        unique case (st_q.divSt)
            DIV_IDLE:
                st_d.divSt = DIV_IDLE;
            DIV_RUN:
            begin
                for (int k = 0; k < 2; k++)
                begin
                    if (st_d.divRem >= {1'b0, st_d.divDen})
                    begin
                        st_d.divQ = {st_d.divQ[24:0], 1'b1};
                        st_d.divRem = st_d.divRem - {1'b0, st_d.divDen};
                    end
                    else
                        st_d.divQ = {st_d.divQ[24:0], 1'b0};
                    st_d.divRem = st_d.divRem << 1;
                end
                st_d.divCnt = st_q.divCnt - 4'h1;
                if (st_q.divCnt == 4'h1)
                    st_d.ready = 1'b1;
                if (st_q.divCnt == 4'h0)
                    st_d.divSt = DIV_WB;
            end
            DIV_WB:
            begin
                // Quotient lies in (0.5, 2); renormalise on the top bit
                e = st_q.divQ[25] ? st_q.divExp : st_q.divExp - 10'h1;
                frac = st_q.divQ[25] ? st_q.divQ[24:2] : st_q.divQ[23:1];
                if (st_q.divSpecial)
                    st_d.fr[st_q.divDst] = st_q.divSpecData;
                else if ($signed(e) >= $signed(EXP_MAX))
                    st_d.fr[st_q.divDst] = {st_q.divSign, 8'hff, 23'h0};
                else if ($signed(e) <= 0)
                    st_d.fr[st_q.divDst] = {st_q.divSign, 31'h0};
                else
                    st_d.fr[st_q.divDst] = {st_q.divSign, e[7:0], frac};
                st_d.cause = st_q.divCause;
                st_d.resValid = 1'b1;
                st_d.divSt = DIV_IDLE;
            end
            default:
                st_d.divSt = DIV_IDLE;
        endcase

        // Second stage retires after the divider, so later program order wins
        if (st_q.stage.valid)
        begin
            st_d.resValid = 1'b1;
            if (st_q.stage.toXfer)
                st_d.xfer = st_q.stage.data;
            else if (st_q.stage.isMac)
            begin
                st_d.fr[st_q.stage.dst] = backRes;
                st_d.cause = backCause | st_q.stage.cause | wbDivCause;
            end
            else
                st_d.fr[st_q.stage.dst] = st_q.stage.data;
        end

        // Issue
        if (taken && isDiv)
        begin
            st_d.ready = 1'b0;
            st_d.divSt = DIV_RUN;
            st_d.divCnt = DIV_STEPS;
            st_d.divDst = dstIdx;
            st_d.divQ = 26'h0;
            st_d.divSign = dstVal[31] ^ srcVal[31];
            st_d.divRem = {2'b01, dstVal[22:0]};
            st_d.divDen = {1'b1, srcVal[22:0]};
            st_d.divExp = {2'b0, dstVal[30:23]} - {2'b0, srcVal[30:23]} + EXP_BIAS;
            st_d.divSpecial = 1'b1;
            st_d.divCause = '0;
            // Special operands; denormals already classify as zero
            if (cNum.nan || cDen.nan)
            begin
                st_d.divSpecData = FP_QNAN;
                st_d.divCause.invalid = cNum.snan || cDen.snan;
            end
            else if ((cNum.zero && cDen.zero) || (cNum.inf && cDen.inf))
            begin
                st_d.divSpecData = FP_QNAN;
                st_d.divCause.invalid = 1'b1;
            end
            else if (cNum.inf || cDen.zero)
            begin
                st_d.divSpecData = {st_d.divSign, 8'hff, 23'h0};
                st_d.divCause.divZero = !cNum.inf;
            end
            else if (cDen.inf || cNum.zero)
                st_d.divSpecData = {st_d.divSign, 31'h0};
            else
            begin
                st_d.divSpecData = FP_ZERO;
                st_d.divSpecial = 1'b0;
            end
        end
        else if (taken && isMac)
        begin
            // Multiply step now, its causes ride along to the add step
            st_d.stage = '{valid: 1'b1, toXfer: 1'b0, isMac: 1'b1, dst: dstIdx,
                           data: frontRes, cause: frontCause};
        end
        else if (taken && isMisc)
        begin
            st_d.stage = '{valid: 1'b1, toXfer: 1'b0, isMac: 1'b0, dst: dstIdx,
                           data: FP_ZERO, cause: '0};
            unique case (srcIdx)
                MID_ZERO:  st_d.stage.data = FP_ZERO;
                MID_ONE:   st_d.stage.data = FP_ONE;
                MID_XFER:
                begin
                    st_d.stage.toXfer = 1'b1;
                    st_d.stage.data = dstVal;
                end
                MID_FLOAT: st_d.stage.data = frontRes;
                default:   st_d.stage.valid = 1'b0;
            endcase
        end
    end

    // ******************************************************************
    // State register
    // ******************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
            st_q.ready <= READY_RESET;
        end
        else
            st_q <= st_d;
    end

    assign issueReady_q  = st_q.ready;
    assign resultValid_q = st_q.resValid;
    assign statusCause_q = st_q.cause;
    assign transferReg_q = st_q.xfer;
    assign rdData_q      = st_q.rdData;

    // ******************************************************************
    // Assertions
    // ******************************************************************
    logic takeZero;
    logic takeOne;
    logic takeCopy;
    logic takeFloatOne;
    logic takeDiv;
    logic takeMac;
    logic divDz;
    logic divInv;
    assign takeZero     = taken && isMisc && srcIdx == MID_ZERO;
    assign takeOne      = taken && isMisc && srcIdx == MID_ONE;
    assign takeCopy     = taken && isMisc && srcIdx == MID_XFER;
    // Transfer word holding the pattern of one is a reachable, exactly known convert
    assign takeFloatOne = taken && isMisc && srcIdx == MID_FLOAT && st_q.xfer == FP_ONE;
    assign takeDiv      = taken && isDiv;
    assign takeMac      = taken && isMac;
    assign divDz        = takeDiv && cDen.zero && !cNum.zero && !cNum.inf && !cNum.nan;
    assign divInv       = takeDiv && cDen.zero && cNum.zero;

    property p_load_zero;
        @(posedge core_clk) disable iff (!reset_n)
        takeZero |=> ##1 st_q.fr[$past(dstIdx, 2)] == FP_ZERO && resultValid_q;
    endproperty
    a_load_zero: assert property (p_load_zero) else $error("load zero wrong");

    property p_load_one;
        @(posedge core_clk) disable iff (!reset_n)
        takeOne |=> ##1 st_q.fr[$past(dstIdx, 2)] == FP_ONE;
    endproperty
    a_load_one: assert property (p_load_one) else $error("load one wrong");

    property p_copy;
        @(posedge core_clk) disable iff (!reset_n)
        takeCopy |=> ##1 transferReg_q == $past(dstVal, 2);
    endproperty
    a_copy: assert property (p_copy) else $error("transfer copy wrong");

    property p_float_one;
        @(posedge core_clk) disable iff (!reset_n)
        takeFloatOne |=> ##1 st_q.fr[$past(dstIdx, 2)] == 32'h4e7e0000;
    endproperty
    a_float_one: assert property (p_float_one) else $error("convert of one wrong");

    property p_div_issue;
        @(posedge core_clk) disable iff (!reset_n)
        takeDiv |=> !issueReady_q ##11 !issueReady_q ##1 issueReady_q;
    endproperty
    a_div_issue: assert property (p_div_issue) else $error("divide issue occupancy wrong");

    property p_div_latency;
        @(posedge core_clk) disable iff (!reset_n)
        takeDiv |-> ##15 resultValid_q;
    endproperty
    a_div_latency: assert property (p_div_latency) else $error("divide result late");

    property p_div_dz;
        @(posedge core_clk) disable iff (!reset_n)
        divDz |-> ##15 statusCause_q.divZero && !statusCause_q.invalid;
    endproperty
    a_div_dz: assert property (p_div_dz) else $error("divide by zero not flagged");

    property p_div_inv;
        @(posedge core_clk) disable iff (!reset_n)
        divInv |-> ##15 statusCause_q.invalid && st_q.fr[$past(dstIdx, 15)] == FP_QNAN;
    endproperty
    a_div_inv: assert property (p_div_inv) else $error("zero over zero not invalid");

    property p_mac_timing;
        @(posedge core_clk) disable iff (!reset_n)
        takeMac |=> issueReady_q ##1 resultValid_q;
    endproperty
    a_mac_timing: assert property (p_mac_timing) else $error("mac timing wrong");

    property p_mac_cause;
        @(posedge core_clk) disable iff (!reset_n)
        takeMac && frontCause.invalid |=> ##1 statusCause_q.invalid;
    endproperty
    a_mac_cause: assert property (p_mac_cause) else $error("multiply cause lost");

endmodule // fdl_fpu_exec
`default_nettype wire

// File: tb/fdl_issue_model.sv
// Partner model: instruction pipeline offering one opcode at a time
`timescale 1ns/1ps
`default_nettype none
module fdl_issue_model
    import fdl_pkg::*;
(
    // Clock and handshake
    input  wire logic        core_clk,
    input  wire logic        issueReady_q,
    // Offered instruction
    output logic             issueValid,
    output logic [15:0]      issueOpcode
);
    // Idle after power up
    initial
    begin
        issueValid  = 1'b0;
        issueOpcode = 16'h0000;
    end

    // Offer just after an edge and hold until an edge takes it
    task automatic issue(input logic [15:0] op);
        issueValid  = 1'b1;
        issueOpcode = op;
        while (issueReady_q !== 1'b1)
        begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        #1;
    endtask

    // Release; the stale word is inverted so nothing can reuse it
    task automatic idle();
        issueValid  = 1'b0;
        issueOpcode = ~issueOpcode;
    endtask
endmodule // fdl_issue_model
`default_nettype wire

// File: tb/fdl_fpu_exec_tb.sv
// Self-checking bench for the floating point execution block
`timescale 1ns/1ps
`default_nettype none
module fdl_fpu_exec_tb
    import fdl_pkg::*;
;
    logic        core_clk;
    logic        reset_n;
    logic [3:0]  rdIdx;
    logic        issueValid;
    logic [15:0] issueOpcode;
    logic        issueReady_q;
    logic        resultValid_q;
    fdl_cause_s  statusCause_q;
    logic [31:0] transferReg_q;
    logic [31:0] rdData_q;
    int          failCount = 0;
    int          compares = 0;

    // ******
    // Design and pipeline partner
    // ******
    fdl_fpu_exec dut_u (.core_clk(core_clk), .reset_n(reset_n), .issueValid(issueValid),
        .issueOpcode(issueOpcode), .issueReady_q(issueReady_q), .resultValid_q(resultValid_q),
        .statusCause_q(statusCause_q), .transferReg_q(transferReg_q), .rdIdx(rdIdx), .rdData_q(rdData_q));
    fdl_issue_model model (.core_clk(core_clk), .issueReady_q(issueReady_q), .issueValid(issueValid),
        .issueOpcode(issueOpcode));

    // 125 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ******
    // Shared tasks
    // ******
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Two edges so the delayed read port has settled
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        rdIdx = idx;
        repeat (2) @(posedge core_clk);
        #1;
        check(rdData_q, exp);
    endtask

    // Bounded wait for the write pulse, counting refused cycles
    task automatic waitRes(output int n, output int low);
        n = 0;
        low = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
            if (issueReady_q === 1'b0)
                low++;
        end while (resultValid_q !== 1'b1 && n < 20);
    endtask

    // Offer one instruction and wait for its result
    task automatic one(input logic [15:0] op, output int n);
        int low;
        model.issue(op);
        model.idle();
        waitRes(n, low);
    endtask

    task automatic div(input logic [15:0] op, input logic [3:0] idx, input logic [31:0] val, input logic [1:0] c);
        int n, low;
        model.issue(op);
        model.idle();
        waitRes(n, low);
        check(32'(n), 32'(DIV_LATENCY));
        // Ready low right after the take is not sampled; the take cycle is not either
        check(32'(low), 32'(DIV_ISSUE_CYC - 2));
        rd(idx, val);
        check({30'h0, statusCause_q}, {30'h0, c});
        $display("divide %h done", op);
    endtask

    // ******
    // Scenarios
    // ******
    task automatic testLoads();
        int n;
        model.issue(16'hf79d);
        model.issue(16'hf19d);
        one(16'hf78d, n);
        check(32'(n), 32'h1);
        rd(4'h7, FP_ZERO);
        rd(4'h1, FP_ONE);
        $display("loads done");
    endtask

    task automatic testCopyConvert();
        int n;
        one(16'hf11d, n);
        check(transferReg_q, FP_ONE);
        one(16'hf32d, n);
        check(32'(n), 32'h1);
        rd(4'h3, 32'h4e7e0000);
        $display("copy and convert done");
    endtask

    task automatic testMac();
        int n;
        model.issue(16'hf09d);
        model.issue(16'hf59d);
        one(16'hf49d, n);
        one(16'hf54e, n);
        check(32'(n), 32'h1);
        one(16'hf54e, n);
        rd(4'h5, 32'h40400000);
        check({30'h0, statusCause_q}, 32'h0);
        $display("mac done");
    endtask

    // Zero times infinity: only the saved multiply cause flags invalid
    task automatic testMacCause();
        int n;
        one(16'hf08d, n);
        one(16'hf93e, n);
        rd(4'h9, FP_QNAN);
        check({30'h0, statusCause_q}, 32'h2);
        $display("mac cause done");
    endtask

    // Single exit for both the normal end and the watchdog
    task automatic endSim();
        $display("compares=%0d fails=%0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog at 2500 cycles, far beyond the ninety or so cycles the tests need
    initial
    begin
        #20000;
        failCount++;
        endSim();
    end

    initial
    begin
        reset_n = 1'b0;
        rdIdx = 4'h0;
        repeat (3) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        @(posedge core_clk);
        #1;
        check({31'h0, issueReady_q}, 32'h1);
        testLoads();
        testCopyConvert();
        testMac();
        div(16'hf153, 4'h1, 32'h3eaaaaaa, 2'b00);
        div(16'hf373, 4'h3, 32'h7f800000, 2'b01);
        testMacCause();
        div(16'hf763, 4'h7, FP_QNAN, 2'b10);
        endSim();
    end
endmodule // fdl_fpu_exec_tb
`default_nettype wire
